// ===== epv_core.v
// exception priority and vectoring with apb control registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`include "epv_defs.vh"

// Function
// - every exception yields 16-bit vector in top window
// - six top vectors for resets and non-maskables
// - fixed non-maskable order, nmi gated by x
// - maskables only while i clear; reset sets i
// - exactly one maskable source may be promoted
// - promoted source still masked, vector unchanged
// - priority register writable only while i set
// - promote value equals vector low byte
// - default maskable order by descending vector
// - nmi level only; external pin level or edge
// - no request left at service gives trap vector
// - edge latch independent, cleared on service of its vector 0xFFF2
// - peripheral flags hold the other requests
// - clock monitor via enables; watchdog on nonzero rate
// - external pin also gated by line enable
// - invalid promote value makes external pin top
// - edge select falling edge, else low level
module epv_core #(
    parameter N = `EPV_NUM_MASKABLE
) (
    // clock and reset
    input  wire          clk_sys_i,
    input  wire          rstn_i,
    // apb slave
    input  wire          psel_i,
    input  wire          penable_i,
    input  wire          pwrite_i,
    input  wire [11:0]   paddr_i,
    input  wire [31:0]   pwdata_i,
    output reg  [31:0]   prdata_o,
    output reg           pready_o,
    output reg           pslverr_o,
    // reset and trap sources
    input  wire          por_req_i,
    input  wire          clkmon_fail_i,
    input  wire          watchdog_fail_i,
    input  wire          illegal_op_i,
    input  wire          swtrap_i,
    // external pins, active low
    input  wire          nmi_pin_n_i,
    input  wire          ext_pin_n_i,
    // peripheral flags, already gated by local enables (index 0 = 0xFFF2, unused)
    input  wire [N-1:0]  periph_flag_i,
    // second converter and key wake-up pins
    input  wire          adc1_flag_i,
    input  wire [7:0]    wake_j_i,
    input  wire [7:0]    wake_h_i,
    // core side
    input  wire          cc_i_set_i,
    input  wire          cc_i_clr_i,
    input  wire          cc_x_clr_i,
    input  wire          service_i,
    output reg           exc_pending_o,
    output reg  [15:0]   vector_o,
    output reg           i_mask_o,
    output reg           x_mask_o
);
    ////////////////////////////////////////////////////////////////////////
    reg  [7:0]  interrupt_control_reg;
    reg  [7:0]  top_priority_select_reg;
    reg  [1:0]  condition_code_reg;
    reg  [15:0] wake_en_reg;
    reg  [7:0]  watchdog_control_reg;
    reg         ext_pin_d_reg;
    reg         edge_latch_reg;
    reg  [15:0] vec_next;
    reg         pend_next;
    wire        edge_only_select     = interrupt_control_reg[`EPV_CTRL_EDGE_BIT];
    wire        external_line_enable = interrupt_control_reg[`EPV_CTRL_EN_BIT];
    wire        i_flag = condition_code_reg[`EPV_CCR_I_BIT];
    wire        x_flag = condition_code_reg[`EPV_CCR_X_BIT];
    wire        wr_en  = psel_i && penable_i && pwrite_i;
    wire        fall   = ext_pin_d_reg && !ext_pin_n_i;

    ////////////////////////////////////////////////////////////////////////
    // maskable request vector assembly
    wire        ext_req = external_line_enable &&
                          (edge_only_select ? edge_latch_reg : !ext_pin_n_i);
    wire        wake_req = |({wake_h_i, wake_j_i} & wake_en_reg);
    reg  [N-1:0] mreq;
    always @* begin
        mreq = periph_flag_i;
        mreq[`EPV_IDX_EXTPIN] = ext_req;
        mreq[`EPV_IDX_ADC]    = periph_flag_i[`EPV_IDX_ADC] | adc1_flag_i;
        mreq[`EPV_IDX_WAKE]   = periph_flag_i[`EPV_IDX_WAKE] | wake_req;
    end

    wire        m_any;
    wire [7:0]  m_low;
    epv_pick #(
        .N          (N)
    ) u_pick (
        .req_i      (mreq),
        .promote_i  (top_priority_select_reg),
        .any_o      (m_any),
        .low_byte_o (m_low)
    );

    ////////////////////////////////////////////////////////////////////////
    // non-maskable chain then maskables
    wire clkmon_en = watchdog_control_reg[`EPV_WDOG_CME_BIT] |
                     watchdog_control_reg[`EPV_WDOG_FORCED_CLOCK_MONITOR_ENABLE_BIT];
    wire wdog_en   = |watchdog_control_reg[`EPV_WDOG_RATE_MSB:`EPV_WDOG_RATE_LSB];
    always @* begin
        pend_next = 1'b1;
        if (por_req_i) begin
            vec_next = `EPV_VEC_RESET;
        end else if (clkmon_fail_i && clkmon_en) begin
            vec_next = `EPV_VEC_CLKMON;
        end else if (watchdog_fail_i && wdog_en) begin
            vec_next = `EPV_VEC_WATCHDOG;
        end else if (illegal_op_i) begin
            vec_next = `EPV_VEC_TRAP;
        end else if (swtrap_i) begin
            vec_next = `EPV_VEC_SWTRAP;
        end else if (!nmi_pin_n_i && !x_flag) begin
            vec_next = `EPV_VEC_NMI;
        end else if (m_any && !i_flag) begin
            vec_next = {`EPV_VEC_HIGH_BYTE, m_low};
        end else if (service_i) begin
            // service started but source vanished
            vec_next = `EPV_VEC_TRAP;
        end else begin
            vec_next  = `EPV_VEC_TRAP;
            pend_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    wire prio_valid = (pwdata_i[7:0] <= `EPV_MASK_TOP_LOW) &&
                      (pwdata_i[7:0] >= `EPV_MASK_BOT_LOW) && !pwdata_i[0];
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            interrupt_control_reg   <= `EPV_CTRL_RESET;
            top_priority_select_reg <= `EPV_PRIO_RESET;
            condition_code_reg      <= `EPV_CCR_RESET;
            wake_en_reg             <= 16'h0000;
            watchdog_control_reg    <= `EPV_WDOG_RESET;
            ext_pin_d_reg           <= 1'b1;
            edge_latch_reg          <= 1'b0;
        end else begin
            ext_pin_d_reg <= ext_pin_n_i;
            // set wins over clear on service
            if (fall) begin
                edge_latch_reg <= 1'b1;
            end else if (service_i && vec_next == {`EPV_VEC_HIGH_BYTE, `EPV_MASK_TOP_LOW}) begin
                edge_latch_reg <= 1'b0;
            end
            if (cc_i_set_i) begin
                condition_code_reg[`EPV_CCR_I_BIT] <= 1'b1;
            end else if (cc_i_clr_i) begin
                condition_code_reg[`EPV_CCR_I_BIT] <= 1'b0;
            end
            // x can only be cleared after reset
            if (cc_x_clr_i) begin
                condition_code_reg[`EPV_CCR_X_BIT] <= 1'b0;
            end
            if (wr_en) begin
                case (paddr_i)
                    `EPV_ADDR_CTRL: begin
                        interrupt_control_reg <= {pwdata_i[7:5], 5'h00};
                    end
                    `EPV_ADDR_PRIO: begin
                        if (i_flag) begin
                            top_priority_select_reg <= prio_valid ? pwdata_i[7:0]
                                                                  : `EPV_PRIO_RESET;
                        end
                    end
                    `EPV_ADDR_CCR: begin
                        condition_code_reg[`EPV_CCR_I_BIT] <= pwdata_i[`EPV_CCR_I_BIT];
                    end
                    `EPV_ADDR_WAKE_EN: begin
                        wake_en_reg <= pwdata_i[15:0];
                    end
                    `EPV_ADDR_WDOG: begin
                        watchdog_control_reg <= pwdata_i[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: one wait-free access phase, error on unmapped address
    reg [31:0] rd_mux;
    reg        hit;
    always @* begin
        hit = 1'b1;
        case (paddr_i)
            `EPV_ADDR_CTRL:    rd_mux = {24'h000000, interrupt_control_reg};
            `EPV_ADDR_PRIO:    rd_mux = {24'h000000, top_priority_select_reg};
            `EPV_ADDR_CCR:     rd_mux = {30'h00000000, condition_code_reg};
            `EPV_ADDR_STATUS:  rd_mux = {14'h0000, edge_latch_reg, pend_next, vec_next};
            `EPV_ADDR_WAKE_EN: rd_mux = {16'h0000, wake_en_reg};
            `EPV_ADDR_WDOG:    rd_mux = {24'h000000, watchdog_control_reg};
            default: begin
                rd_mux = 32'h00000000;
                hit    = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered core outputs, one cycle after request sampling
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exc_pending_o <= 1'b0;
            vector_o      <= `EPV_VEC_RESET;
            i_mask_o      <= 1'b1;
            x_mask_o      <= 1'b1;
        end else begin
            exc_pending_o <= pend_next;
            vector_o      <= vec_next;
            i_mask_o      <= i_flag;
            x_mask_o      <= x_flag;
        end
    end
endmodule

// ===== epv_defs.vh
// constants for the exception priority and vectoring block
`ifndef EPV_DEFS_VH
`define EPV_DEFS_VH

// vector addresses of the non-maskable sources
`define EPV_VEC_RESET      16'hFFFE
`define EPV_VEC_CLKMON     16'hFFFC
`define EPV_VEC_WATCHDOG   16'hFFFA
`define EPV_VEC_TRAP       16'hFFF8
`define EPV_VEC_SWTRAP     16'hFFF6
`define EPV_VEC_NMI        16'hFFF4

// maskable window
`define EPV_VEC_HIGH_BYTE  8'hFF
`define EPV_MASK_TOP_LOW   8'hF2
`define EPV_MASK_BOT_LOW   8'h80
`define EPV_NUM_MASKABLE   58

// source indices inside the maskable request vector (index 0 = 0xFFF2)
`define EPV_IDX_EXTPIN     0
`define EPV_IDX_TICK       1
`define EPV_IDX_ADC        16
`define EPV_IDX_WAKE       18

// register offsets and reset values
`define EPV_ADDR_CTRL      12'h000
`define EPV_ADDR_PRIO      12'h004
`define EPV_ADDR_CCR       12'h008
`define EPV_ADDR_STATUS    12'h00C
`define EPV_ADDR_WAKE_EN   12'h010
`define EPV_ADDR_WDOG      12'h014
`define EPV_CTRL_RESET     8'h60
`define EPV_PRIO_RESET     8'hF2
`define EPV_CCR_RESET      2'h3
`define EPV_WDOG_RESET     8'h00

// bit positions
`define EPV_CTRL_EDGE_BIT  7
`define EPV_CTRL_EN_BIT    6
`define EPV_CCR_I_BIT      0
`define EPV_CCR_X_BIT      1
`define EPV_WDOG_CME_BIT   7
`define EPV_WDOG_FORCED_CLOCK_MONITOR_ENABLE_BIT  6
`define EPV_WDOG_RATE_LSB  0
`define EPV_WDOG_RATE_MSB  2

`endif

// ===== epv_pick.v
// fixed-order maskable arbiter with one promoted source
`timescale 1ns/1ns
`include "epv_defs.vh"

module epv_pick #(
    parameter N = `EPV_NUM_MASKABLE
) (
    // requests, already gated
    input  wire [N-1:0] req_i,
    // promoted source low byte
    input  wire [7:0]   promote_i,
    // result
    output wire         any_o,
    output wire [7:0]   low_byte_o
);
    reg [7:0] low_of [0:N-1];
    reg [7:0] pick;
    reg       found;
    integer   k;

    // lowest index wins (highest vector); found flags an earlier winner
    always @* begin
        pick  = `EPV_MASK_TOP_LOW;
        found = 1'b0;
        for (k = 0; k < N; k = k + 1) begin
            low_of[k] = `EPV_MASK_TOP_LOW - k[6:0] * 2'd2;
            if (req_i[k] && !found) begin
                pick  = low_of[k];
                found = 1'b1;
            end
        end
        // promoted source jumps ahead; its vector is unchanged
        for (k = 0; k < N; k = k + 1) begin
            if (req_i[k] && low_of[k] == promote_i) begin
                pick = low_of[k];
            end
        end
    end

    assign any_o      = found;
    assign low_byte_o = pick;
endmodule

// ===== epv_core_properties.sv
// concurrent checks on the ports of the exception priority block
`timescale 1ns/1ns
module epv_core_properties (
    // clock, reset and bus
    input wire        clk_sys_i,
    input wire        rstn_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pready_o,
    input wire        pslverr_o,
    // request sources and core side
    input wire        por_req_i,
    input wire        clkmon_fail_i,
    input wire        watchdog_fail_i,
    input wire        illegal_op_i,
    input wire        swtrap_i,
    input wire        nmi_pin_n_i,
    input wire        cc_i_set_i,
    input wire        cc_i_clr_i,
    input wire        cc_x_clr_i,
    input wire        service_i,
    input wire        exc_pending_o,
    input wire [15:0] vector_o,
    input wire        i_mask_o,
    input wire        x_mask_o
);
    wire no_hi = !por_req_i && !clkmon_fail_i && !watchdog_fail_i && !illegal_op_i && !swtrap_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////
    chk_reset_wins: assert property (por_req_i |=> vector_o == 16'hFFFE && exc_pending_o)
        else $error("reset request did not win");
    chk_vec_window: assert property (vector_o[15:7] == 9'h1FF && !vector_o[0])
        else $error("vector outside the top window");
    // the mask copy lags the flag by one cycle, so look at it one cycle on
    chk_mask_blocks: assert property (no_hi && nmi_pin_n_i && !service_i ##1 i_mask_o |-> !exc_pending_o)
        else $error("request seen while masked");
    chk_nmi_vector: assert property (!x_mask_o && !nmi_pin_n_i && no_hi |=> vector_o == 16'hFFF4)
        else $error("nonmaskable pin vector wrong");
    chk_x_sticky: assert property ($fell(x_mask_o) |-> $past(cc_x_clr_i, 2))
        else $error("x mask cleared without request");
    chk_i_set: assert property (cc_i_set_i |-> ##2 i_mask_o)
        else $error("i mask not set");
    chk_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    chk_ready_phase: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_trap_empty: assert property (service_i && no_hi && nmi_pin_n_i && i_mask_o |=> vector_o == 16'hFFF8)
        else $error("empty service not trapped");
endmodule

// ===== epv_req_model.sv
// external requester on the maskable pin, level or edge style
`timescale 1ns/1ns
module epv_req_model (
    // clock and reset
    input  wire clk_sys_i,
    input  wire rstn_i,
    // control from the bench and the core
    input  wire raise_i,
    input  wire hold_i,
    input  wire service_i,
    // pin with pull-up, active low
    output reg  ext_pin_n_o
);
    reg [1:0] cnt_reg;
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_pin_n_o <= 1'b1;
            cnt_reg <= 2'h0;
        end else if (raise_i) begin
            ext_pin_n_o <= 1'b0;
            cnt_reg <= 2'h2;
        end else begin
            // level style waits for the service handshake before letting go
            if (hold_i ? service_i : cnt_reg == 2'h1)
                ext_pin_n_o <= 1'b1;
            if (cnt_reg != 2'h0)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule

// ===== exception_priority_vectoring_bench.sv
// self-checking bench for the exception priority block
`timescale 1ns/1ns
module exception_priority_vectoring_bench;
    reg         clk_sys_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    reg  [11:0] paddr_i = 12'h000;
    reg  [31:0] pwdata_i = 32'h0, rd;
    reg  [57:0] periph_flag_i = 58'h0;
    reg  [7:0]  wake_j_i = 8'h00, wake_h_i = 8'h00;
    reg  [5:0]  src = 6'h00;
    reg         adc1_flag_i = 0, cc_i_set_i = 0, cc_i_clr_i = 0, cc_x_clr_i = 0, service_i = 0;
    reg         raise = 0, hold = 1, er;
    integer     n_fail = 0, checks_done = 0, cyc = 0, k;
    wire [31:0] prdata_o;
    wire [15:0] vector_o;
    wire        pready_o, pslverr_o, exc_pending_o, i_mask_o, x_mask_o, ext_pin_n_i;
    wire        nmi_pin_n_i = ~src[0], swtrap_i = src[1], illegal_op_i = src[2];
    wire        watchdog_fail_i = src[3], clkmon_fail_i = src[4], por_req_i = src[5];
    epv_core u_epv_core (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .por_req_i, .clkmon_fail_i, .watchdog_fail_i, .illegal_op_i, .swtrap_i,
        .nmi_pin_n_i, .ext_pin_n_i, .periph_flag_i, .adc1_flag_i, .wake_j_i, .wake_h_i, .cc_i_set_i,
        .cc_i_clr_i, .cc_x_clr_i, .service_i, .exc_pending_o, .vector_o, .i_mask_o, .x_mask_o);
    epv_req_model u_epv_req_model (.clk_sys_i, .rstn_i, .raise_i(raise), .hold_i(hold), .service_i,
        .ext_pin_n_o(ext_pin_n_i));
    always #5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////
    task stop_test;
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    task tick(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waits on ready with no assumed latency; the cycle limit cuts a hang
    task bus(input [11:0] a, input w, input [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1;
        // sample settled answer, then release after the edge that takes it
        @(negedge clk_sys_i);
        while (pready_o !== 1'b1) @(negedge clk_sys_i);
        rd = prdata_o;
        er = pslverr_o;
        @(posedge clk_sys_i);
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task cv(input [16:0] e);
        tick(3);
        cmp({15'h0, exc_pending_o, vector_o}, {15'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        rstn_i <= 1;
        cv(17'h0FFF8);
        cmp({i_mask_o, x_mask_o}, 2'h3);
        bus(12'h000, 0, 0); cmp(rd, 32'h60);
        bus(12'h008, 0, 0); cmp(rd, 32'h3);
        bus(12'h014, 0, 0); cmp(rd, 32'h0);
        bus(12'h020, 0, 0); cmp({rd, er}, 33'h1);
        bus(12'h004, 1, 32'hF6); bus(12'h004, 0, 0); cmp(rd, 32'hF2);
        bus(12'h004, 1, 32'hD2); bus(12'h004, 0, 0); cmp(rd, 32'hD2);
        bus(12'h008, 1, 32'h0); tick(2); cmp(i_mask_o, 1'b0);
        bus(12'h004, 1, 32'hF0); bus(12'h004, 0, 0); cmp(rd, 32'hD2);
        periph_flag_i <= 58'h4;
        adc1_flag_i <= 1;
        cv(17'h1FFD2);
        adc1_flag_i <= 0;
        cv(17'h1FFEE);
        periph_flag_i <= 58'h0;
        bus(12'h010, 1, 32'h100);
        wake_h_i <= 8'h01;
        cv(17'h1FFCE);
        wake_h_i <= 8'h00;
        periph_flag_i <= 58'h4;
        cc_i_set_i <= 1; tick(1); cc_i_set_i <= 0;
        cv(17'h0FFF8);
        periph_flag_i <= 58'h0;
        cc_i_clr_i <= 1; tick(1); cc_i_clr_i <= 0;
        bus(12'h000, 1, 32'h0);
        raise <= 1; tick(1); raise <= 0;
        cv(17'h0FFF8);
        bus(12'h000, 1, 32'h40);
        cv(17'h1FFF2);
        service_i <= 1; tick(1); service_i <= 0;
        cv(17'h0FFF8);
        bus(12'h000, 1, 32'hC0);
        hold <= 0;
        raise <= 1; tick(1); raise <= 0;
        tick(4);
        cv(17'h1FFF2);
        service_i <= 1; tick(1); service_i <= 0;
        cv(17'h0FFF8);
        bus(12'h014, 1, 32'h81);
        src[0] <= 1;
        cv(17'h0FFF8);
        cc_x_clr_i <= 1; tick(1); cc_x_clr_i <= 0;
        for (k = 0; k < 6; k = k + 1) begin
            src[k] <= 1;
            cv({1'b1, 16'hFFF4 + 16'(2 * k)});
        end
        src <= 6'h00;
        cc_i_set_i <= 1; tick(1); cc_i_set_i <= 0;
        service_i <= 1; tick(1); service_i <= 0;
        @(negedge clk_sys_i);
        cmp({15'h0, exc_pending_o, vector_o}, {15'h0, 17'h1FFF8});
        stop_test;
    end
endmodule
bind epv_core epv_core_properties u_epv_core_properties (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pready_o,
    .pslverr_o, .por_req_i, .clkmon_fail_i, .watchdog_fail_i, .illegal_op_i, .swtrap_i, .nmi_pin_n_i,
    .cc_i_set_i, .cc_i_clr_i, .cc_x_clr_i, .service_i, .exc_pending_o, .vector_o, .i_mask_o, .x_mask_o);
